//--- hdl/store_byte_picker.sv
// picks one byte of a word, leftmost byte first
`timescale 1ns/100ps
`default_nettype none

module store_byte_picker
(
	// word and byte position
	input  wire logic [31:0] word_i,
	input  wire logic [1:0]  idx_i,
	// selected byte
	output logic      [7:0]  byte_o
);

	// index 0 is the most significant byte
	always_comb
	begin
		unique case (idx_i)
			2'h0: byte_o = word_i[31:24];
			2'h1: byte_o = word_i[23:16];
			2'h2: byte_o = word_i[15:8];
			2'h3: byte_o = word_i[7:0];
		endcase
	end

endmodule : store_byte_picker

`default_nettype wire

//--- hdl/store_instruction_unit.sv
// decoder and sequencer for halfword, multiple, quadword and string stores
`timescale 1ns/100ps
`default_nettype none
`include "store_unit_defs.svh"

module store_instruction_unit #(
	parameter int XLEN    = 64,
	parameter bit IMPL_64 = 1'b1
)
(
	// clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                rst_b_i,
	// instruction issue
	input  wire logic                insn_valid_i,
	input  wire logic [31:0]         insn_i,
	output logic                     insn_ready_o,
	// exception register count source
	input  wire logic [XLEN-1:0]     fixed_exception_reg_i,
	// register file read port, data answers the index standing in the same cycle
	output logic      [4:0]          gpr_rd_idx_o,
	input  wire logic [XLEN-1:0]     gpr_rd_data_i,
	// data memory store port
	output logic                     mem_req_o,
	output logic      [XLEN-1:0]     mem_addr_o,
	output logic      [2*XLEN-1:0]   mem_data_o,
	output logic      [4:0]          mem_size_o,
	input  wire logic                mem_ready_i,
	// completion and errors
	output logic                     done_o,
	output logic                     illegal_o,
	output logic                     invalid_form_o
);

	typedef struct packed {
		store_unit_pkg::su_state_t st;
		store_unit_pkg::su_kind_t  kind;
		logic                      indexed;
		logic [4:0]                src;
		logic [4:0]                base_sel;
		logic [4:0]                index_sel;
		logic [4:0]                rd_idx;
		logic [XLEN-1:0]           disp;
		logic [XLEN-1:0]           base;
		logic [XLEN-1:0]           eff_addr;
		logic [XLEN-1:0]           hi;
		logic [31:0]               word;
		logic [6:0]                remain;
		logic [1:0]                bidx;
		logic                      req;
		logic [XLEN-1:0]           addr;
		logic [2*XLEN-1:0]         data;
		logic [4:0]                size;
		logic                      ready;
		logic                      done;
		logic                      illegal;
		logic                      invalid;
	} unit_state_t;

	unit_state_t r_reg;
	unit_state_t r_next;

	logic [5:0]  prim;
	logic [9:0]  xo;
	logic [31:0] pick_word;
	logic [1:0]  pick_idx;
	logic [7:0]  pick_byte;
	logic [XLEN-1:0] base_val;

	assign prim = insn_i[31:26];
	assign xo   = insn_i[10:1];

	// the picker serves both the first byte of a word and the ones after it
	assign pick_word = (r_reg.st == store_unit_pkg::S_GET_S) ? gpr_rd_data_i[31:0] : r_reg.word;
	assign pick_idx  = (r_reg.st == store_unit_pkg::S_MEM) ? r_reg.bidx + 2'h1 : r_reg.bidx;
	assign base_val  = (r_reg.base_sel == 5'h00) ? '0 : gpr_rd_data_i;

	store_byte_picker u_pick (
		.word_i (pick_word),
		.idx_i  (pick_idx),
		.byte_o (pick_byte)
	);

	always_comb
	begin
		r_next         = r_reg;
		r_next.done    = 1'b0;
		r_next.illegal = 1'b0;
		r_next.invalid = 1'b0;
		unique case (r_reg.st)
			store_unit_pkg::S_IDLE:
			begin
				if (insn_valid_i)
				begin
					r_next.src     = insn_i[25:21];
					r_next.base_sel  = insn_i[20:16];
					r_next.index_sel = insn_i[15:11];
					r_next.rd_idx  = insn_i[20:16];
					r_next.bidx    = 2'h0;
					r_next.disp    = '0;
					r_next.indexed = 1'b0;
					r_next.st      = store_unit_pkg::S_GET_A;
					r_next.ready   = 1'b0;
					if (prim == `SU_OP_EXT && xo == `SU_XO_HALF_X)
					begin
						r_next.kind    = store_unit_pkg::K_HALF;
						r_next.indexed = 1'b1;
					end
					else if (prim == `SU_OP_EXT && xo == `SU_XO_STR_IDX)
					begin
						r_next.kind    = store_unit_pkg::K_STR;
						r_next.indexed = 1'b1;
						r_next.remain  = fixed_exception_reg_i[6:0];
					end
					else if (prim == `SU_OP_EXT && xo == `SU_XO_STR_IMM)
					begin
						r_next.kind   = store_unit_pkg::K_STR;
						r_next.remain = (insn_i[15:11] == 5'h00) ?
							`SU_STR_ZERO_COUNT : {2'h0, insn_i[15:11]};
					end
					else if (prim == `SU_OP_MULT)
					begin
						r_next.kind = store_unit_pkg::K_MULT;
						r_next.disp = {{(XLEN-16){insn_i[15]}}, insn_i[15:0]};
					end
					else if (prim == `SU_OP_QUAD && insn_i[1:0] == `SU_QUAD_LOW)
					begin
						r_next.kind = store_unit_pkg::K_QUAD;
						r_next.disp = {{(XLEN-16){insn_i[15]}}, insn_i[15:2], 2'h0};
						if (!IMPL_64)
						begin
							r_next.illegal = 1'b1;
							r_next.st      = store_unit_pkg::S_IDLE;
							r_next.ready   = 1'b1;
						end
						else if (insn_i[21])
						begin
							r_next.invalid = 1'b1;
							r_next.st      = store_unit_pkg::S_IDLE;
							r_next.ready   = 1'b1;
						end
					end
					else
					begin
						// anything else is not ours and is refused at once
						r_next.illegal = 1'b1;
						r_next.st      = store_unit_pkg::S_IDLE;
						r_next.ready   = 1'b1;
					end
				end
			end
			store_unit_pkg::S_GET_A:
			begin
				r_next.base = base_val;
				if (r_reg.indexed)
				begin
					r_next.rd_idx = r_reg.index_sel;
					r_next.st     = store_unit_pkg::S_GET_B;
				end
				else
				begin
					r_next.eff_addr = base_val + r_reg.disp;
					r_next.rd_idx = r_reg.src;
					r_next.st     = store_unit_pkg::S_GET_S;
				end
			end
			store_unit_pkg::S_GET_B:
			begin
				r_next.eff_addr = r_reg.base + gpr_rd_data_i;
				r_next.rd_idx = r_reg.src;
				r_next.st     = store_unit_pkg::S_GET_S;
			end
			store_unit_pkg::S_GET_S:
			begin
				r_next.word = gpr_rd_data_i[31:0];
				r_next.addr = r_reg.eff_addr;
				r_next.data = '0;
				if (r_reg.kind == store_unit_pkg::K_QUAD)
				begin
					r_next.hi     = gpr_rd_data_i;
					r_next.rd_idx = r_reg.src + 5'h01;
					r_next.st     = store_unit_pkg::S_GET_S2;
				end
				else if (r_reg.kind == store_unit_pkg::K_STR && r_reg.remain == 7'h00)
				begin
					r_next.st    = store_unit_pkg::S_IDLE;
					r_next.ready = 1'b1;
					r_next.done  = 1'b1;
				end
				else
				begin
					r_next.req = 1'b1;
					r_next.st  = store_unit_pkg::S_MEM;
					if (r_reg.kind == store_unit_pkg::K_HALF)
					begin
						r_next.data[15:0] = gpr_rd_data_i[15:0];
						r_next.size       = `SU_SIZE_HALF;
					end
					else if (r_reg.kind == store_unit_pkg::K_MULT)
					begin
						// an unaligned address is passed through as is
						r_next.data[31:0] = gpr_rd_data_i[31:0];
						r_next.size       = `SU_SIZE_WORD;
					end
					else
					begin
						r_next.data[7:0] = pick_byte;
						r_next.size      = `SU_SIZE_BYTE;
					end
				end
			end
			store_unit_pkg::S_GET_S2:
			begin
				r_next.data = {r_reg.hi, gpr_rd_data_i};
				r_next.size = `SU_SIZE_QUAD;
				r_next.req  = 1'b1;
				r_next.st   = store_unit_pkg::S_MEM;
			end
			store_unit_pkg::S_MEM:
			begin
				if (mem_ready_i)
				begin
					r_next.req = 1'b0;
					if (r_reg.kind == store_unit_pkg::K_MULT && r_reg.src != `SU_LAST_REG)
					begin
						r_next.src    = r_reg.src + 5'h01;
						r_next.rd_idx = r_reg.src + 5'h01;
						r_next.eff_addr = r_reg.eff_addr + XLEN'(`SU_WORD_STEP);
						r_next.st     = store_unit_pkg::S_GET_S;
					end
					else if (r_reg.kind == store_unit_pkg::K_STR && r_reg.remain != 7'h01)
					begin
						r_next.remain = r_reg.remain - 7'h01;
						r_next.eff_addr = r_reg.eff_addr + XLEN'(1);
						r_next.bidx   = r_reg.bidx + 2'h1;
						if (r_reg.bidx == 2'h3)
						begin
							r_next.src    = r_reg.src + 5'h01;
							r_next.rd_idx = r_reg.src + 5'h01;
							r_next.st     = store_unit_pkg::S_GET_S;
						end
						else
						begin
							r_next.req       = 1'b1;
							r_next.addr      = r_reg.eff_addr + XLEN'(1);
							r_next.data[7:0] = pick_byte;
						end
					end
					else
					begin
						// no path writes the exception register, condition field or
						// multiply quotient register, so those stay as they were
						r_next.st    = store_unit_pkg::S_IDLE;
						r_next.ready = 1'b1;
						r_next.done  = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			r_reg       <= '0;
			r_reg.ready <= 1'b1;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign insn_ready_o   = r_reg.ready;
	assign gpr_rd_idx_o   = r_reg.rd_idx;
	assign mem_req_o      = r_reg.req;
	assign mem_addr_o     = r_reg.addr;
	assign mem_data_o     = r_reg.data;
	assign mem_size_o     = r_reg.size;
	assign done_o         = r_reg.done;
	assign illegal_o      = r_reg.illegal;
	assign invalid_form_o = r_reg.invalid;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	logic accept;
	assign accept = insn_valid_i && insn_ready_o;

	property p_half_data;
		(r_reg.st == store_unit_pkg::S_GET_S && r_reg.kind == store_unit_pkg::K_HALF)
			|=> mem_req_o && mem_size_o == `SU_SIZE_HALF
				&& mem_data_o[15:0] == $past(gpr_rd_data_i[15:0]);
	endproperty
	a_half_data: assert property (p_half_data) else $error("halfword data wrong");

	property p_idx_addr;
		(r_reg.st == store_unit_pkg::S_GET_B && r_reg.base_sel == 5'h00)
			|=> r_reg.eff_addr == $past(gpr_rd_data_i);
	endproperty
	a_idx_addr: assert property (p_idx_addr) else $error("index-only address wrong");

	property p_mult_next;
		(mem_req_o && mem_ready_i && r_reg.kind == store_unit_pkg::K_MULT
			&& r_reg.src != `SU_LAST_REG)
			|=> gpr_rd_idx_o == 5'($past(r_reg.src) + 5'h01) ##1 mem_req_o
				&& mem_addr_o == $past(mem_addr_o, 2) + XLEN'(`SU_WORD_STEP);
	endproperty
	a_mult_next: assert property (p_mult_next) else $error("multiple step wrong");

	property p_quad_size;
		(mem_req_o && r_reg.kind == store_unit_pkg::K_QUAD) |-> mem_size_o == `SU_SIZE_QUAD;
	endproperty
	a_quad_size: assert property (p_quad_size) else $error("quad size wrong");

	property p_quad_odd;
		(accept && prim == `SU_OP_QUAD && insn_i[1:0] == `SU_QUAD_LOW && insn_i[21] && IMPL_64)
			|=> invalid_form_o && insn_ready_o && !mem_req_o;
	endproperty
	a_quad_odd: assert property (p_quad_odd) else $error("odd quad not refused");

	property p_quad_32;
		(accept && prim == `SU_OP_QUAD && insn_i[1:0] == `SU_QUAD_LOW && !IMPL_64)
			|=> illegal_o;
	endproperty
	a_quad_32: assert property (p_quad_32) else $error("quad on 32-bit not illegal");

	property p_imm_zero;
		(accept && prim == `SU_OP_EXT && xo == `SU_XO_STR_IMM && insn_i[15:11] == 5'h00)
			|=> r_reg.remain == `SU_STR_ZERO_COUNT;
	endproperty
	a_imm_zero: assert property (p_imm_zero) else $error("zero count not 32");

	property p_idx_count;
		(accept && prim == `SU_OP_EXT && xo == `SU_XO_STR_IDX)
			|=> r_reg.remain == $past(fixed_exception_reg_i[6:0]);
	endproperty
	a_idx_count: assert property (p_idx_count) else $error("string count wrong");

	property p_str_byte;
		(mem_req_o && r_reg.kind == store_unit_pkg::K_STR)
			|-> mem_size_o == `SU_SIZE_BYTE && mem_data_o[2*XLEN-1:8] == '0;
	endproperty
	a_str_byte: assert property (p_str_byte) else $error("string not bytewise");

	property p_wrap;
		(mem_req_o && mem_ready_i && r_reg.kind == store_unit_pkg::K_STR && r_reg.bidx == 2'h3
			&& r_reg.remain != 7'h01 && r_reg.src == `SU_LAST_REG)
			|=> gpr_rd_idx_o == 5'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("register number did not wrap");

endmodule : store_instruction_unit

`default_nettype wire

//--- hdl/store_unit_defs.svh
// opcode, field and size constants for the store instruction unit
`ifndef STORE_UNIT_DEFS_SVH
`define STORE_UNIT_DEFS_SVH

`define SU_OP_EXT          6'h1F
`define SU_OP_MULT         6'h2F
`define SU_OP_QUAD         6'h3E
`define SU_QUAD_LOW        2'h2
`define SU_XO_HALF_X       10'h197
`define SU_XO_STR_IMM      10'h2D5
`define SU_XO_STR_IDX      10'h295
`define SU_LAST_REG        5'h1F
`define SU_STR_ZERO_COUNT  7'h20
`define SU_SIZE_BYTE       5'h01
`define SU_SIZE_HALF       5'h02
`define SU_SIZE_WORD       5'h04
`define SU_SIZE_QUAD       5'h10
`define SU_WORD_STEP       3'h4

`endif

//--- hdl/store_unit_pkg.sv
// state and instruction kind types for the store instruction unit
package store_unit_pkg;

	typedef enum logic [2:0] {
		S_IDLE,
		S_GET_A,
		S_GET_B,
		S_GET_S,
		S_GET_S2,
		S_MEM
	} su_state_t;

	typedef enum logic [1:0] {
		K_HALF,
		K_MULT,
		K_QUAD,
		K_STR
	} su_kind_t;

endpackage : store_unit_pkg

//--- testbench/store_mem_model.sv
// register file and data memory model facing the store unit
`timescale 1ns/100ps
`default_nettype none

module store_mem_model
(
	// clock and test control
	input  wire logic        core_clk_i,
	input  wire logic        slow_i,
	// register read port and store handshake
	input  wire logic [4:0]  gpr_rd_idx_i,
	output logic      [63:0] gpr_rd_data_o,
	output logic             mem_ready_o
);
	// each register holds distinct bytes so a wrong pick or order shows;
	// the unit reads the data in the cycle its registered index stands
	always_comb
	begin
		gpr_rd_data_o = 64'h9000_0000_1020_3040 + 64'h0100_0000_0101_0101 * 64'(gpr_rd_idx_i);
	end
	// slow mode takes every other cycle, so stalls land inside a register
	always_ff @(posedge core_clk_i)
	begin
		mem_ready_o <= slow_i ? ~mem_ready_o : 1'b1;
	end
endmodule : store_mem_model
`default_nettype wire

//--- testbench/tb.sv
// self-checking testbench for the store instruction unit
`timescale 1ns/100ps
`default_nettype none

module tb;
	typedef struct packed {logic [63:0] a; logic [127:0] d; logic [4:0] s;} store_t;
	logic         core_clk_i   = 1'b0;
	logic         rst_b_i      = 1'b0;
	logic         insn_valid_i = 1'b0;
	logic [31:0]  insn_i       = 32'h0;
	logic [63:0]  fx_reg       = 64'h0;
	logic         illegal_32;
	logic         slow         = 1'b0;
	logic         insn_ready_o, mem_req_o, mem_ready, done_o, illegal_o, invalid_form_o;
	logic [4:0]   gpr_rd_idx_o, mem_size_o;
	logic [63:0]  gpr_rd_data, mem_addr_o;
	logic [127:0] mem_data_o;
	store_t       exp_q[$];
	store_t       got_q[$];
	int           bad_count = 0;
	int           compares  = 0;
	int           narrow_count = 0;

	always #12.5 core_clk_i = ~core_clk_i;

	store_instruction_unit #(.XLEN(64), .IMPL_64(1'b1)) u_store_instruction_unit (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .insn_valid_i(insn_valid_i),
		.insn_i(insn_i), .insn_ready_o(insn_ready_o), .fixed_exception_reg_i(fx_reg),
		.gpr_rd_idx_o(gpr_rd_idx_o), .gpr_rd_data_i(gpr_rd_data), .mem_req_o(mem_req_o),
		.mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .mem_size_o(mem_size_o),
		.mem_ready_i(mem_ready), .done_o(done_o), .illegal_o(illegal_o),
		.invalid_form_o(invalid_form_o));

	store_mem_model u_store_mem_model (.core_clk_i(core_clk_i), .slow_i(slow),
		.gpr_rd_idx_i(gpr_rd_idx_o), .gpr_rd_data_o(gpr_rd_data), .mem_ready_o(mem_ready));

	// narrow build runs in lock step on the same inputs; only its refusals are judged
	store_instruction_unit #(.XLEN(64), .IMPL_64(1'b0)) u_store_instruction_unit_32 (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .insn_valid_i(insn_valid_i),
		.insn_i(insn_i), .insn_ready_o(), .fixed_exception_reg_i(fx_reg),
		.gpr_rd_idx_o(), .gpr_rd_data_i(gpr_rd_data), .mem_req_o(), .mem_addr_o(),
		.mem_data_o(), .mem_size_o(), .mem_ready_i(mem_ready), .done_o(),
		.illegal_o(illegal_32), .invalid_form_o());

	always @(posedge core_clk_i)
	begin
		if (illegal_32 === 1'b1)
			narrow_count++;
	end

	always @(posedge core_clk_i)
	begin
		if (mem_req_o === 1'b1 && mem_ready === 1'b1)
			got_q.push_back('{mem_addr_o, mem_data_o, mem_size_o});
	end

	function automatic logic [63:0] rv(input logic [4:0] i);
		return 64'h9000_0000_1020_3040 + 64'h0100_0000_0101_0101 * 64'(i);
	endfunction : rv

	function automatic logic [31:0] xf(input logic [4:0] src, base, idx, input logic [9:0] xo);
		return {6'h1F, src, base, idx, xo, 1'b0};
	endfunction : xf

	function automatic logic [31:0] df(input logic [5:0] op, input logic [4:0] src, base,
		input logic [15:0] d);
		return {op, src, base, d};
	endfunction : df

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic want(input logic [63:0] a, input logic [127:0] d, input logic [4:0] s);
		exp_q.push_back('{a, d, s});
	endtask : want

	// string bytes: leftmost first, register number wraps past 31
	task automatic want_str(input logic [63:0] start, input logic [4:0] first, input int n);
		for (int k = 0; k < n; k++)
			want(start + 64'(k), 128'(8'(rv(first + 5'(k / 4)) >> (24 - 8 * (k % 4)))), 5'h01);
	endtask : want_str

	// offers one instruction, waits for its outcome, then judges the stores taken
	task automatic run(input logic [31:0] insn, input logic [63:0] fx, input int kind);
		int           seen;
		logic [127:0] m;
		seen = -1;
		@(posedge core_clk_i);
		insn_valid_i <= 1'b1;
		insn_i       <= insn;
		fx_reg       <= fx;
		@(posedge core_clk_i);
		insn_valid_i <= 1'b0;
		for (int c = 0; c < 400 && seen < 0; c++)
		begin
			@(negedge core_clk_i);
			if (done_o === 1'b1)
				seen = 0;
			else if (illegal_o === 1'b1)
				seen = 1;
			else if (invalid_form_o === 1'b1)
				seen = 2;
		end
		check("outcome", 128'(seen), 128'(kind));
		check("store count", 128'(got_q.size()), 128'(exp_q.size()));
		while (exp_q.size() > 0 && got_q.size() > 0)
		begin
			m = (128'h1 << (8 * exp_q[0].s)) - 128'h1;
			check("store address", 128'(got_q[0].a), 128'(exp_q[0].a));
			check("store size", 128'(got_q[0].s), 128'(exp_q[0].s));
			check("store data", got_q[0].d & m, exp_q[0].d);
			void'(exp_q.pop_front());
			void'(got_q.pop_front());
		end
		exp_q.delete();
		got_q.delete();
	endtask : run

	task automatic t_half;
		want(rv(4) + rv(5), 128'(16'(rv(6))), 5'h02);
		run(xf(5'h06, 5'h04, 5'h05, 10'h197), 64'h0, 0);
		want(rv(5), 128'(16'(rv(6))), 5'h02);
		run(xf(5'h06, 5'h00, 5'h05, 10'h197), 64'h0, 0);
	endtask : t_half

	task automatic t_mult;
		for (int i = 0; i < 3; i++)
			want(rv(3) - 64'h8 + 64'(4 * i), 128'(32'(rv(5'(29 + i)))), 5'h04);
		run(df(6'h2F, 5'h1D, 5'h03, 16'hFFF8), 64'h0, 0);
		// unaligned start under a stalling memory: address is issued as computed
		slow = 1'b1;
		want(64'h106, 128'(32'(rv(5'h1F))), 5'h04);
		run(df(6'h2F, 5'h1F, 5'h00, 16'h0106), 64'h0, 0);
	endtask : t_mult

	task automatic t_quad;
		slow = 1'b0;
		want(rv(3) - 64'h8, {rv(4), rv(5)}, 5'h10);
		run(df(6'h3E, 5'h04, 5'h03, 16'hFFFA), 64'h0, 0);
		want(64'h14, {rv(10), rv(11)}, 5'h10);
		run(df(6'h3E, 5'h0A, 5'h00, 16'h0016), 64'h0, 0);
		run(df(6'h3E, 5'h05, 5'h03, 16'h0016), 64'h0, 2);
		// the narrow build refuses all three; the last pulse is counted at the next edge
		@(negedge core_clk_i);
		check("narrow quad illegal", 128'(narrow_count), 128'h3);
	endtask : t_quad

	task automatic t_string;
		slow = 1'b1;
		want_str(rv(4), 5'h1F, 5);
		run(xf(5'h1F, 5'h04, 5'h05, 10'h2D5), 64'h0, 0);
		slow = 1'b0;
		want_str(64'h0, 5'h00, 32);
		run(xf(5'h00, 5'h00, 5'h00, 10'h2D5), 64'h7, 0);
		want_str(rv(4) + rv(5), 5'h06, 6);
		run(xf(5'h06, 5'h04, 5'h05, 10'h295), 64'h86, 0);
		want_str(rv(5), 5'h1E, 9);
		run(xf(5'h1E, 5'h00, 5'h05, 10'h295), 64'h09, 0);
		run(xf(5'h06, 5'h04, 5'h05, 10'h295), 64'h80, 0);
	endtask : t_string

	task automatic t_illegal;
		run(32'h0000_0000, 64'h0, 1);
		run(xf(5'h06, 5'h04, 5'h05, 10'h001), 64'h0, 1);
	endtask : t_illegal

	initial
	begin
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		check("ready in reset", 128'(insn_ready_o), 128'h1);
		check("request in reset", 128'(mem_req_o), 128'h0);
		@(posedge core_clk_i);
		rst_b_i <= 1'b1;
		t_half();
		t_mult();
		t_quad();
		t_string();
		t_illegal();
		final_report();
	end

	// the whole sequence needs well under two thousand cycles
	initial
	begin
		#100000;
		bad_count++;
		final_report();
	end
endmodule : tb
`default_nettype wire
